/* spigp_consts.svh */
// Constants of the serial port clock-stop and general-purpose pin block.
// Included by the core only; definitions only.
`ifndef SPIGP_CONSTS_SVH
`define SPIGP_CONSTS_SVH

// ==========================================================
// Widths and counts
`define SPIGP_WORD_BITS 8
`define SPIGP_DIV_BITS 8
`define SPIGP_SYNC_STAGES 3
`define SPIGP_PIN_COUNT 5

// ==========================================================
// Clock-stop codes
`define SPIGP_STOP_HALF 2'h2
`define SPIGP_STOP_FULL 2'h3

// ==========================================================
// General-purpose pin positions
`define SPIGP_GP_TX_CLK 0
`define SPIGP_GP_TX_FS 1
`define SPIGP_GP_RX_CLK 2
`define SPIGP_GP_RX_FS 3
`define SPIGP_GP_DATA 4

// ==========================================================
// Reset values
`define SPIGP_RST_LEVEL 1'h0
`define SPIGP_RST_OE_B 1'h1

`endif

/* spigp_pkg.sv */
// Types of the serial port clock-stop and general-purpose pin block.
// Assumes spigp_consts.svh is on the include path.
package spigp_pkg;

  // ==========================================================
  // Master clock engine states
  typedef enum logic [1:0] {
    SPIGP_IDLE,
    SPIGP_LEAD,
    SPIGP_CLOCK,
    SPIGP_TAIL
  } spigp_state_type;

endpackage

/* spigp_sync.sv */
// Pin input synchroniser: three stages plus an output flip-flop per bit, output follows
// once the second and third stages agree.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module spigp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] st1_q;
  logic [WIDTH-1:0] st2_q;
  logic [WIDTH-1:0] st3_q;
  logic [WIDTH-1:0] agree;

  assign agree = ~(st2_q ^ st3_q);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
      sync_out <= '0;
    end else begin
      st1_q <= async_in;
      st2_q <= st1_q;
      st3_q <= st2_q;
      sync_out <= (agree & st3_q) | (~agree & sync_out);
    end
  end

endmodule // spigp_sync

/* spigp_core.sv */
// Serial port in clock-stop (SPI) mode, master or slave, with
// general-purpose use of the port pins.
// Assumes one clock sys_clk, which also stands for the CPU clock, so
// one sys_clk period equals 2H; configuration inputs are static.
`timescale 1ns/1ps
`include "spigp_consts.svh"
module spigp_core import spigp_pkg::*; #(
  parameter int WORD_BITS = `SPIGP_WORD_BITS,
  parameter int DIV_BITS = `SPIGP_DIV_BITS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_enable,
  input wire logic master_mode,
  input wire logic [1:0] clock_stop_select,
  input wire logic tx_clock_polarity,
  input wire logic [DIV_BITS-1:0] generator_divider,
  input wire logic tx_clock_direction,
  input wire logic rx_clock_direction,
  input wire logic tx_sync_direction,
  input wire logic rx_sync_direction,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic [WORD_BITS-1:0] tx_word,
  input wire logic tx_start,
  output logic busy,
  output logic [WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  input wire logic gpio_enable,
  input wire logic [`SPIGP_PIN_COUNT-1:0] gpio_dir,
  input wire logic [`SPIGP_PIN_COUNT-1:0] gpio_out,
  output logic [`SPIGP_PIN_COUNT-1:0] gpio_in,
  input wire logic tx_shift_clock_pin_in,
  output logic tx_shift_clock_pin_out,
  output logic tx_shift_clock_pin_oe_b,
  input wire logic tx_frame_sync_pin_in,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe_b,
  output logic tx_serial_data_pin_out,
  output logic tx_serial_data_pin_oe_b,
  input wire logic rx_shift_clock_pin_in,
  output logic rx_shift_clock_pin_out,
  output logic rx_shift_clock_pin_oe_b,
  input wire logic rx_frame_sync_pin_in,
  output logic rx_frame_sync_pin_out,
  output logic rx_frame_sync_pin_oe_b,
  input wire logic rx_serial_data_pin_in
);

  localparam int CW = DIV_BITS + 1;
  localparam int BW = $clog2(WORD_BITS + 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_BITS);
  localparam logic [BW-1:0] PRE_LAST = BW'(WORD_BITS - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  // ==========================================================
  // Pin input synchronisers
  logic [`SPIGP_PIN_COUNT-1:0] pin_raw;
  logic [`SPIGP_PIN_COUNT-1:0] pin_s;

  assign pin_raw = {rx_serial_data_pin_in, rx_frame_sync_pin_in,
                    rx_shift_clock_pin_in, tx_frame_sync_pin_in,
                    tx_shift_clock_pin_in};

  spigp_sync #(.WIDTH(`SPIGP_PIN_COUNT)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  // ==========================================================
  // Mode decode
  logic spi_mode;
  logic is_master;
  logic is_slave;
  logic stop_half;
  logic inv_enable;
  logic slave_tx_en;
  logic slave_rx_en;

  assign spi_mode = spi_enable & ~gpio_enable;
  assign is_master = spi_mode & master_mode;
  assign is_slave = spi_mode & ~master_mode;
  assign stop_half = (clock_stop_select == `SPIGP_STOP_HALF);
  assign inv_enable = tx_sync_polarity & rx_sync_polarity;
  assign slave_tx_en = tx_sync_polarity ? ~pin_s[1] : pin_s[1];
  assign slave_rx_en = rx_sync_polarity ? ~pin_s[3] : pin_s[3];

  // ==========================================================
  // Phase lengths in sys_clk cycles; divider 0 runs as 1
  logic [CW-1:0] div_eff;
  logic [CW-1:0] per_len;
  logic [CW-1:0] low_len;
  logic [CW-1:0] high_len;
  logic [CW-1:0] idle_len;

  assign div_eff = (generator_divider == '0) ? ONE : CW'(generator_divider);
  assign per_len = div_eff + ONE;
  assign low_len = div_eff[0] ? (per_len >> 1) : (div_eff >> 1);
  assign high_len = div_eff[0] ? (per_len >> 1)
                               : ((div_eff >> 1) + ONE);
  assign idle_len = tx_clock_polarity ? high_len : low_len;

  // ==========================================================
  // Master clock engine
  spigp_state_type st_q;
  spigp_state_type st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic sclk_q;
  logic sclk_d;
  logic m_fs_q;
  logic m_fs_d;
  logic m_lead;
  logic m_trail;
  logic m_done;
  logic [BW-1:0] bits_q;
  logic act_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sclk_d = sclk_q;
    m_fs_d = m_fs_q;
    m_lead = 1'b0;
    m_trail = 1'b0;
    m_done = 1'b0;
    unique case (st_q)
      SPIGP_IDLE: begin
        sclk_d = tx_clock_polarity;
        if (is_master && tx_start) begin
          st_d = SPIGP_LEAD;
          m_fs_d = 1'b1;
          cnt_d = stop_half ? idle_len - ONE : per_len - ONE;
        end
      end
      SPIGP_LEAD: begin
        if (cnt_q == '0) begin
          st_d = SPIGP_CLOCK;
          sclk_d = ~sclk_q;
          m_lead = 1'b1;
          cnt_d = (sclk_q ? low_len : high_len) - ONE;
        end else begin
          cnt_d = cnt_q - ONE;
        end
      end
      SPIGP_CLOCK: begin
        if (cnt_q == '0) begin
          sclk_d = ~sclk_q;
          m_lead = (sclk_q == tx_clock_polarity);
          m_trail = ~m_lead;
          cnt_d = (sclk_q ? low_len : high_len) - ONE;
          if (m_trail && (stop_half ? bits_q == PRE_LAST
                                    : bits_q == LAST_BIT)) begin
            m_done = 1'b1;
            st_d = SPIGP_TAIL;
            cnt_d = stop_half ? per_len - ONE : idle_len - ONE;
          end
        end else begin
          cnt_d = cnt_q - ONE;
        end
      end
      SPIGP_TAIL: begin
        if (cnt_q == '0) begin
          st_d = SPIGP_IDLE;
          m_fs_d = 1'b0;
        end else begin
          cnt_d = cnt_q - ONE;
        end
      end
    endcase
    if (!is_master) begin
      st_d = SPIGP_IDLE;
      m_fs_d = 1'b0;
      sclk_d = tx_clock_polarity;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SPIGP_IDLE;
      cnt_q <= '0;
      sclk_q <= `SPIGP_RST_LEVEL;
      m_fs_q <= `SPIGP_RST_LEVEL;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sclk_q <= sclk_d;
      m_fs_q <= m_fs_d;
    end
  end

  // ==========================================================
  // Slave edge detection on the synchronised pins
  logic s_clk_prev_q;
  logic s_en_prev_q;
  logic s_lead;
  logic s_trail;
  logic s_begin;
  logic s_end;

  assign s_lead = (pin_s[0] != s_clk_prev_q) &&
                  (pin_s[0] != tx_clock_polarity);
  assign s_trail = (pin_s[0] != s_clk_prev_q) &&
                   (pin_s[0] == tx_clock_polarity);
  assign s_begin = is_slave & slave_tx_en & ~s_en_prev_q;
  assign s_end = is_slave & ~slave_tx_en & s_en_prev_q;

  // ==========================================================
  // Shift engine shared by master and slave
  logic [WORD_BITS-1:0] hold_q;
  logic [WORD_BITS-1:0] tx_sh_q;
  logic [WORD_BITS-1:0] rx_sh_q;
  logic ev_lead;
  logic ev_trail;
  logic launch_ev;
  logic sample_ev;
  logic do_launch;
  logic do_sample;
  logic start_ev;
  logic end_ev;
  logic [WORD_BITS-1:0] rx_sh_d;

  assign ev_lead = is_master ? m_lead : s_lead;
  assign ev_trail = is_master ? m_trail : s_trail;
  assign launch_ev = stop_half ? ev_lead : ev_trail;
  assign sample_ev = stop_half ? ev_trail : ev_lead;
  assign start_ev = (is_master && st_q == SPIGP_IDLE && tx_start) || s_begin;
  assign end_ev = m_done || s_end;
  assign do_launch = act_q && launch_ev && bits_q != '0 &&
                     bits_q != LAST_BIT;
  assign do_sample = act_q && sample_ev && bits_q != LAST_BIT &&
                     (is_master || slave_rx_en);
  // Word as it stands after this cycle's sample; in half clock-stop mode
  // the last master bit is sampled on the same edge that ends the word
  assign rx_sh_d = do_sample ? {rx_sh_q[WORD_BITS-2:0], pin_s[4]}
                             : rx_sh_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_clk_prev_q <= `SPIGP_RST_LEVEL;
      s_en_prev_q <= `SPIGP_RST_LEVEL;
      hold_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      bits_q <= '0;
      act_q <= 1'b0;
    end else begin
      s_clk_prev_q <= pin_s[0];
      s_en_prev_q <= is_slave & slave_tx_en;
      if (tx_start && !act_q) begin
        hold_q <= tx_word;
      end
      if (start_ev) begin
        tx_sh_q <= (is_master || tx_start) ? tx_word : hold_q;
        bits_q <= '0;
        act_q <= 1'b1;
      end else begin
        if (end_ev || !spi_mode) begin
          act_q <= 1'b0;
        end
        if (do_launch) begin
          tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
        end
        if (do_sample) begin
          rx_sh_q <= rx_sh_d;
          bits_q <= bits_q + BW'(1);
        end
      end
    end
  end

  // ==========================================================
  // Pin drive selection
  logic [`SPIGP_PIN_COUNT-1:0] out_d;
  logic [`SPIGP_PIN_COUNT-1:0] oe_b_d;
  logic [`SPIGP_PIN_COUNT-1:0] spi_out;
  logic [`SPIGP_PIN_COUNT-1:0] spi_drv;
  logic fs_pin;
  logic word_done;

  assign fs_pin = inv_enable ? ~m_fs_q : m_fs_q;
  assign spi_out = {tx_sh_q[WORD_BITS-1], fs_pin, sclk_q, fs_pin, sclk_q};
  assign spi_drv = {act_q & spi_mode,
                    is_master & rx_sync_direction,
                    is_master & rx_clock_direction,
                    is_master & tx_sync_direction,
                    is_master & tx_clock_direction};
  assign out_d = gpio_enable ? gpio_out : spi_out;
  assign oe_b_d = gpio_enable ? ~gpio_dir : ~spi_drv;
  assign word_done = end_ev && act_q &&
                     (m_done || bits_q == LAST_BIT);

  // ==========================================================
  // Output registers, all on the CPU clock rising edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_clock_pin_out <= `SPIGP_RST_LEVEL;
      tx_frame_sync_pin_out <= `SPIGP_RST_LEVEL;
      rx_shift_clock_pin_out <= `SPIGP_RST_LEVEL;
      rx_frame_sync_pin_out <= `SPIGP_RST_LEVEL;
      tx_serial_data_pin_out <= `SPIGP_RST_LEVEL;
      tx_shift_clock_pin_oe_b <= `SPIGP_RST_OE_B;
      tx_frame_sync_pin_oe_b <= `SPIGP_RST_OE_B;
      rx_shift_clock_pin_oe_b <= `SPIGP_RST_OE_B;
      rx_frame_sync_pin_oe_b <= `SPIGP_RST_OE_B;
      tx_serial_data_pin_oe_b <= `SPIGP_RST_OE_B;
      gpio_in <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      tx_shift_clock_pin_out <= out_d[`SPIGP_GP_TX_CLK];
      tx_frame_sync_pin_out <= out_d[`SPIGP_GP_TX_FS];
      rx_shift_clock_pin_out <= out_d[`SPIGP_GP_RX_CLK];
      rx_frame_sync_pin_out <= out_d[`SPIGP_GP_RX_FS];
      tx_serial_data_pin_out <= out_d[`SPIGP_GP_DATA];
      tx_shift_clock_pin_oe_b <= oe_b_d[`SPIGP_GP_TX_CLK];
      tx_frame_sync_pin_oe_b <= oe_b_d[`SPIGP_GP_TX_FS];
      rx_shift_clock_pin_oe_b <= oe_b_d[`SPIGP_GP_RX_CLK];
      rx_frame_sync_pin_oe_b <= oe_b_d[`SPIGP_GP_RX_FS];
      tx_serial_data_pin_oe_b <= oe_b_d[`SPIGP_GP_DATA];
      gpio_in <= pin_s;
      rx_valid <= word_done;
      if (word_done) begin
        rx_word <= rx_sh_d;
      end
      busy <= start_ev | (act_q & ~end_ev) | (st_d != SPIGP_IDLE);
    end
  end

endmodule // spigp_core

/* spigp_monitor.sv */
// Checker of shift clock timing, enable framing and pin use.
// Assumes it is bound into every spigp_core; one clock sys_clk.
`timescale 1ns/1ps
module spigp_monitor #(
  parameter int DIV_BITS = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_enable,
  input wire logic master_mode,
  input wire logic gpio_enable,
  input wire logic [1:0] clock_stop_select,
  input wire logic [DIV_BITS-1:0] generator_divider,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic [4:0] gpio_dir,
  input wire logic [4:0] gpio_out,
  input wire logic busy,
  input wire logic rx_valid,
  input wire logic tx_shift_clock_pin_out,
  input wire logic tx_frame_sync_pin_out,
  input wire logic tx_serial_data_pin_out,
  input wire logic tx_serial_data_pin_oe_b
);
  // ==========================================================
  // Phase counters
  logic ck_q;
  logic [9:0] run_q;
  logic [9:0] per_q;
  logic [3:0] rise_q;
  wire ck = tx_shift_clock_pin_out;
  wire rise = ck && !ck_q;
  wire fall = !ck && ck_q;
  wire m_on = spi_enable && master_mode && !gpio_enable;
  wire pol = tx_sync_polarity && rx_sync_polarity;
  wire [9:0] dv = (generator_divider == '0) ? 10'h1 : 10'(generator_divider);
  wire [9:0] lo = dv[0] ? (dv + 10'h1) >> 1 : dv >> 1;
  wire [9:0] hi = dv[0] ? (dv + 10'h1) >> 1 : (dv >> 1) + 10'h1;
  wire [9:0] lead = (clock_stop_select == 2'h2) ? lo : dv + 10'h1;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_q <= 1'h0;
      run_q <= 10'h0;
      per_q <= 10'h0;
      rise_q <= 4'h0;
    end else begin
      ck_q <= ck;
      run_q <= (ck != ck_q) ? 10'h1 : run_q + 10'h1;
      per_q <= (!busy || rise) ? 10'h1 : per_q + 10'h1;
      rise_q <= !busy ? 4'h0 : rise_q + 4'(rise);
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_period_length: assert property (
    m_on && busy && rise && rise_q != 4'h0 |-> per_q == dv + 10'h1)
    else $error("shift clock period wrong");
  a_low_phase: assert property (
    m_on && busy && rise && rise_q != 4'h0 |-> run_q == lo)
    else $error("shift clock low phase wrong");
  a_high_phase: assert property (
    m_on && busy && fall |-> run_q == hi)
    else $error("shift clock high phase wrong");
  a_enable_lead: assert property (
    m_on && busy && rise && rise_q == 4'h0 |-> per_q == lead + 10'h2)
    else $error("enable lead time wrong");
  a_enable_first: assert property (
    m_on && pol && rise |-> !tx_frame_sync_pin_out)
    else $error("enable not low at clock rise");
  a_sample_stable: assert property (
    m_on && busy && !tx_serial_data_pin_oe_b &&
    ((clock_stop_select == 2'h2) ? fall : rise)
    |-> $stable(tx_serial_data_pin_out))
    else $error("data moved on sampling edge");
  a_last_release: assert property (
    m_on && busy && fall && rise_q == 4'h8
    |-> tx_serial_data_pin_oe_b && $past(rx_valid))
    else $error("data not released after last bit");
  a_gpio_drive: assert property (
    gpio_enable |=> tx_shift_clock_pin_out == $past(gpio_out[0]) &&
    tx_serial_data_pin_oe_b == !$past(gpio_dir[4]))
    else $error("general pin output wrong");
endmodule // spigp_monitor

bind spigp_core spigp_monitor #(.DIV_BITS(DIV_BITS)) u_monitor (.*);

/* spigp_peer.sv */
// Far-side SPI slave device answering the core as master.
// Assumes pins seen on sys_clk; select is active low.
`timescale 1ns/1ps
module spigp_peer (
  input wire logic sys_clk,
  input wire logic sel_b,
  input wire logic sck,
  input wire logic mosi,
  input wire logic mosi_oe_b,
  input wire logic sample_rise,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  logic sck_q = 1'h0;
  logic sel_q = 1'h1;
  logic mosi_q = 1'h0;
  logic [7:0] sh_q = 8'h00;
  wire hit = !sel_b && sck != sck_q && sck == sample_rise;
  initial miso = 1'h0;
  initial got = 8'h00;
  always @(posedge sys_clk) begin
    sck_q <= sck;
    sel_q <= sel_b;
    mosi_q <= mosi_oe_b ? 1'hx : mosi;
    if (sel_q && !sel_b) begin
      sh_q <= reply;
      miso <= reply[7];
    end else if (hit) begin
      got <= {got[6:0], mosi_q};
      sh_q <= {sh_q[6:0], 1'h0};
      miso <= sh_q[6];
    end else if (sel_b) begin
      miso <= ~miso;
    end
  end
endmodule // spigp_peer

/* tb_top.sv */
// Bench: master words against the peer, slave words driven here,
// then general pin use. Assumes the monitor binds itself.
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Connections
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic spi_enable = 1'h1;
  logic master_mode = 1'h1;
  logic [1:0] clock_stop_select = 2'h2;
  logic tx_clock_polarity = 1'h0;
  logic [7:0] generator_divider = 8'h09;
  logic tx_clock_direction = 1'h1;
  logic rx_clock_direction = 1'h0;
  logic tx_sync_direction = 1'h1;
  logic rx_sync_direction = 1'h0;
  logic tx_sync_polarity = 1'h1;
  logic rx_sync_polarity = 1'h1;
  logic [7:0] tx_word = 8'h00;
  logic tx_start = 1'h0;
  logic gpio_enable = 1'h0;
  logic [4:0] gpio_dir = 5'h00;
  logic [4:0] gpio_out = 5'h00;
  logic [4:0] drv = 5'h0A;
  logic use_peer = 1'h1;
  logic [7:0] reply = 8'h00;
  logic busy, rx_valid, miso;
  logic [7:0] rx_word, got, mi;
  logic [4:0] gpio_in;
  logic tx_shift_clock_pin_out, tx_shift_clock_pin_oe_b;
  logic tx_frame_sync_pin_out, tx_frame_sync_pin_oe_b;
  logic tx_serial_data_pin_out, tx_serial_data_pin_oe_b;
  logic rx_shift_clock_pin_out, rx_shift_clock_pin_oe_b;
  logic rx_frame_sync_pin_out, rx_frame_sync_pin_oe_b;
  wire tx_shift_clock_pin_in =
    tx_shift_clock_pin_oe_b ? drv[0] : tx_shift_clock_pin_out;
  wire tx_frame_sync_pin_in =
    tx_frame_sync_pin_oe_b ? drv[1] : tx_frame_sync_pin_out;
  wire rx_shift_clock_pin_in =
    rx_shift_clock_pin_oe_b ? drv[2] : rx_shift_clock_pin_out;
  wire rx_frame_sync_pin_in =
    rx_frame_sync_pin_oe_b ? drv[3] : rx_frame_sync_pin_out;
  wire rx_serial_data_pin_in = use_peer ? miso : drv[4];
  wire [4:0] pin_out = {tx_serial_data_pin_out, rx_frame_sync_pin_out,
    rx_shift_clock_pin_out, tx_frame_sync_pin_out, tx_shift_clock_pin_out};
  wire [4:0] pin_oe_b = {tx_serial_data_pin_oe_b, rx_frame_sync_pin_oe_b,
    rx_shift_clock_pin_oe_b, tx_frame_sync_pin_oe_b, tx_shift_clock_pin_oe_b};
  int mismatches = 0;
  int comparisons = 0;
  int vcount = 0;
  int v0 = 0;

  spigp_core dut (.*);
  spigp_peer peer (.sys_clk(sys_clk), .sel_b(tx_frame_sync_pin_out),
    .sck(tx_shift_clock_pin_out), .mosi(tx_serial_data_pin_out),
    .mosi_oe_b(tx_serial_data_pin_oe_b),
    .sample_rise(clock_stop_select != 2'h2), .reply(reply),
    .miso(miso), .got(got));

  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rx_valid === 1'h1) vcount++;

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_idle;
    for (int n = 0; busy !== 1'h0; n++) begin
      @(negedge sys_clk);
      if (n > 3000) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask
  function automatic logic seen_bit;
    return tx_serial_data_pin_oe_b ? 1'hx : tx_serial_data_pin_out;
  endfunction
  task automatic slave_word(input logic [7:0] mo, output logic [7:0] ms);
    drv = 5'h00;
    repeat (12) @(negedge sys_clk);
    for (int b = 7; b >= 0; b--) begin
      repeat (5) @(negedge sys_clk);
      drv[4] = mo[b];
      repeat (5) @(negedge sys_clk);
      if (clock_stop_select == 2'h3) ms[b] = seen_bit();
      drv = drv | 5'h05;
      repeat (10) @(negedge sys_clk);
      if (clock_stop_select == 2'h2) ms[b] = seen_bit();
      drv = drv & 5'h1A;
    end
    repeat (10) @(negedge sys_clk);
    drv = 5'h0A;
    repeat (12) @(negedge sys_clk);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'h1;
    for (int i = 0; i < 4; i++) begin
      clock_stop_select = i[0] ? 2'h3 : 2'h2;
      generator_divider = i[1] ? 8'h0A : 8'h09;
      tx_word = 8'h96 + 8'(i);
      reply = 8'h3C ^ 8'(i);
      v0 = vcount;
      tx_start = 1'h1;
      @(negedge sys_clk);
      tx_start = 1'h0;
      wait_idle();
      chk("peer word", got, tx_word);
      chk("master rx", rx_word, reply);
      chk("master valid", 8'(vcount - v0), 8'h01);
    end
    master_mode = 1'h0;
    tx_clock_direction = 1'h0;
    tx_sync_direction = 1'h0;
    generator_divider = 8'h01;
    use_peer = 1'h0;
    for (int i = 0; i < 2; i++) begin
      clock_stop_select = i[0] ? 2'h3 : 2'h2;
      tx_word = 8'hC3 - 8'(i);
      tx_start = 1'h1;
      @(negedge sys_clk);
      tx_start = 1'h0;
      v0 = vcount;
      slave_word(8'h5A ^ 8'(i), mi);
      chk("slave tx", mi, tx_word);
      chk("slave rx", rx_word, 8'h5A ^ 8'(i));
      chk("slave oe", {7'h0, tx_serial_data_pin_oe_b}, 8'h01);
      chk("slave valid", 8'(vcount - v0), 8'h01);
    end
    gpio_enable = 1'h1;
    for (int i = 0; i < 2; i++) begin
      gpio_dir = 5'h1F;
      gpio_out = i[0] ? 5'h0A : 5'h15;
      repeat (2) @(negedge sys_clk);
      chk("gpio out", {3'h0, pin_out}, {3'h0, gpio_out});
      chk("gpio oe", {3'h0, pin_oe_b}, 8'h00);
      gpio_dir = 5'h00;
      drv = ~gpio_out;
      repeat (8) @(negedge sys_clk);
      chk("gpio hiz", {3'h0, pin_oe_b}, 8'h1F);
      chk("gpio in", {3'h0, gpio_in}, {3'h0, ~gpio_out});
    end
    report_and_stop();
  end
endmodule // tb_top
